// *** verification/hd_ctrl_tb.sv ***
`timescale 1ns/1ps
module hd_ctrl_tb;
	import hd_pkg::*;
	localparam int unsigned C0 = 300;
	localparam int unsigned C1 = 600;
	localparam int unsigned C2 = 1200;
	int unsigned dur [3] = '{C0, C1, C2};
	logic       clk;
	logic       rst_n = 1'b0;
	logic       en = 1'b0;
	logic       hot = 1'b0;
	logic       bemf = 1'b0;
	logic       zdone = 1'b0;
	logic       wdone = 1'b0;
	logic [7:0] zval = 8'h00;
	logic [7:0] lvl = 8'h00;
	logic [7:0] per = 8'h00;
	logic       oen, scl, sda_m, zrun, wrun, crun, flt, adl, adf;
	logic [1:0] dmode;
	logic [7:0] peak, olp, clv, cpr, pv;
	logic [3:0] dsw;
	logic [2:0] brk;
	logic [1:0] lgn, zcw;
	logic       sdo;
	logic       trig = 1'b0;
	wire        sda = sda_m & oen;
	logic [7:0] exp_q [$];
	logic [7:0] obs_q [$];
	logic [31:0] rs = 32'd1576;
	int         bad_count = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         cnt = 0;
	int         k;
	logic [7:0] p, o, z, l, q;
	logic       a;

	hd_host host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	hd_ctrl #(.CAL_CYC_250(C0), .CAL_CYC_500(C1), .CAL_CYC_1S(C2)) dut (
		.CLK(clk), .RESETN(rst_n), .SCL(scl), .SDA_IN(sda),
		.SDA_OUT(sdo), .SDA_OEN(oen), .EN(en), .TRIG_PIN(trig),
		.UNDERVOLTAGE_LOCKOUT(1'b0), .OVERTEMP(hot),
		.OVERCURRENT(1'b0), .SHORT_LOAD(1'b0), .OPEN_LOAD(1'b0),
		.BEMF_VALID(bemf), .ZMEAS_DONE(zdone), .ZMEAS_VALUE(zval),
		.DIAG_WAVE_DONE(wdone), .CAL_LEVEL_IN(lvl), .CAL_PERIOD_IN(per),
		.DRIVE_MODE(dmode), .ADAPT_LEVEL(adl), .ADAPT_FREQ(adf),
		.ZMEAS_RUN(zrun), .DIAG_WAVE_RUN(wrun), .CAL_RUN(crun),
		.FAULT_FLAG(flt), .PEAK_DRIVE_LIMIT(peak),
		.OPEN_LOOP_RESONANT_PERIOD(olp), .FEEDBACK_BRAKE_GAIN(brk),
		.LOOP_GAIN(lgn), .DISCHARGE_WAIT(dsw),
		.CROSSING_DETECT_WINDOW(zcw),
		.CAL_LEVEL(clv), .CAL_PERIOD(cpr));

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (crun === 1'b1)
			cnt <= cnt + 1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end
	initial forever begin
		wait (obs_q.size() > 0);
		cmp_byte(exp_q.pop_front(), obs_q.pop_front());
	end

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic note(input logic [7:0] e, input logic [7:0] g);
		exp_q.push_back(e);
		obs_q.push_back(g);
	endtask
	task automatic wbyte(input logic [7:0] d);
		logic [7:0] r;
		logic       ak;
		host.byte_io(d, 1'b1, r, ak);
		note(8'h00, {7'h0, ak});
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d0,
		input logic [7:0] d1, input int n);
		host.start();
		wbyte({HD_DEV_ADDR, 1'b0});
		wbyte(r);
		wbyte(d0);
		if (n > 1)
			wbyte(d1);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] r, input logic [7:0] e0,
		input logic [7:0] e1, input int n);
		logic [7:0] v;
		logic       ak;
		host.start();
		wbyte({HD_DEV_ADDR, 1'b0});
		wbyte(r);
		host.start();
		wbyte({HD_DEV_ADDR, 1'b1});
		host.byte_io(8'hff, n == 1, v, ak);
		note(e0, v);
		if (n > 1) begin
			host.byte_io(8'hff, 1'b1, v, ak);
			note(e1, v);
		end
		host.stop();
	endtask
	task automatic pin_pulse();
		@(posedge clk) trig <= 1'b1;
		tick(4);
		@(posedge clk) trig <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		rst_n <= 1'b1;
		tick(8);
		p = rnd();
		o = rnd();
		wr(HD_REG_PEAK, p, o, 2);
		note(p, peak);
		note(o, olp);
		rd(HD_REG_PEAK, p, o, 2);
		rd(HD_REG_OLPER, o, 8'h00, 1);
		host.start();
		host.byte_io({HD_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
		note(8'h01, {7'h0, a});
		host.stop();
		wr(HD_REG_TIMING, 8'h01, 8'h00, 1);
		note(8'h01, {2'h0, zcw, dsw});
		note(8'h00, {7'h0, sdo});
		$display("test bus done");
		for (int i = 0; i < 4; i++) begin
			wr(HD_REG_MODE, {4'h0, i[1], i[0], 2'h0}, 8'h00, 1);
			note({6'h0, i[1], ~i[0]}, {6'h0, dmode});
		end
		$display("test drive mode done");
		z = rnd();
		zval <= z;
		en <= 1'b1;
		wr(HD_REG_MODE, {6'h0, HD_MODE_DIAG}, 8'h01, 2);
		note(8'h01, {7'h0, zrun});
		@(posedge clk) zdone <= 1'b1;
		@(posedge clk) zdone <= 1'b0;
		tick(4);
		note(8'h00, {7'h0, flt});
		note(8'h01, {7'h0, wrun});
		@(posedge clk) wdone <= 1'b1;
		@(posedge clk) wdone <= 1'b0;
		tick(6);
		note(8'h01, {7'h0, flt});
		rd(HD_REG_ZRES, z, 8'h00, 1);
		bemf <= 1'b1;
		wr(HD_REG_GO, 8'h01, 8'h00, 1);
		note(8'h00, {7'h0, flt});
		@(posedge clk) zdone <= 1'b1;
		@(posedge clk) zdone <= 1'b0;
		tick(4);
		@(posedge clk) wdone <= 1'b1;
		@(posedge clk) wdone <= 1'b0;
		tick(6);
		note(8'h00, {7'h0, flt});
		note(8'h00, {7'h0, wrun});
		wr(HD_REG_GO, 8'h01, 8'h00, 1);
		hot <= 1'b1;
		tick(8);
		note(8'h00, {7'h0, zrun});
		note(8'h01, {7'h0, flt});
		hot <= 1'b0;
		$display("test diagnostic done");
		for (int c = 0; c < 4; c++) begin
			l = rnd();
			lvl <= l;
			per <= ~l;
			// pass 1 calibrates an eccentric actuator: period kept
			pv = (c == 1) ? pv : ~l;
			o = {4'h1, 1'b0, c == 1, HD_MODE_CAL};
			wr(HD_REG_MODE, o, 8'h00, 2);
			wr(HD_REG_CALCFG, {3'h2, 3'h3, c[1:0]}, 8'h00, 1);
			cnt = 0;
			if (c == 3) begin
				pin_pulse();
				tick(C2);
				pin_pulse();
			end else begin
				wr(HD_REG_GO, 8'h01, 8'h00, 1);
			end
			k = 0;
			while (crun === 1'b1 && k < 3000) begin
				tick(1);
				k++;
			end
			if (c < 3)
				note(8'h01, {7'h0, cnt + 2 >= dur[c] && cnt <= dur[c] + 2});
			tick(4);
			note(l, clv);
			note(pv, cpr);
			rd(HD_REG_GO, 8'h00, 8'h00, 1);
			rd(HD_REG_STATUS, 8'h04, 8'h00, 1);
		end
		note(8'h13, {3'h0, lgn, brk});
		note(8'h03, {6'h0, adf, adl});
		$display("test calibration done");
		en <= 1'b0;
		wr(HD_REG_MODE, 8'h00, 8'h00, 1);
		tick(10);
		rd(HD_REG_CLEVEL, l, ~l, 2);
		$display("test retention done");
		tick(4);
		final_report();
	end
endmodule

// *** verification/hd_host.sv ***
`timescale 1ns/1ps
module hd_host (
	// bus side
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		@(posedge clk) sda_m <= b;
		tick(3);
		@(posedge clk) scl <= 1'b1;
		// three cycles high, five low: 400 ns per bit
		tick(2);
		@(posedge clk) r = sda;
		scl <= 1'b0;
	endtask
	// serves as start and repeated start; waits out a slave ack first
	task automatic start();
		@(posedge clk) sda_m <= 1'b1;
		tick(5);
		@(posedge clk) scl <= 1'b1;
		tick(3);
		@(posedge clk) sda_m <= 1'b0;
		tick(3);
		@(posedge clk) scl <= 1'b0;
	endtask
	task automatic stop();
		@(posedge clk) sda_m <= 1'b0;
		tick(5);
		@(posedge clk) scl <= 1'b1;
		tick(3);
		@(posedge clk) sda_m <= 1'b1;
		tick(3);
	endtask
	// mack is the ninth bit: 1 releases the line
	task automatic byte_io(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(mack, a);
	endtask
endmodule

// *** verilog/hd_ctrl.sv ***
`timescale 1ns/1ps
module hd_ctrl
	import hd_pkg::*;
#(
	parameter int unsigned CAL_CYC_250 = HD_CAL_CYC0,
	parameter int unsigned CAL_CYC_500 = HD_CAL_CYC1,
	parameter int unsigned CAL_CYC_1S  = HD_CAL_CYC2
)(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESETN,
	// serial bus
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OEN,
	// pins
	input  wire logic       EN,
	input  wire logic       TRIG_PIN,
	// protection and load sense
	input  wire logic       UNDERVOLTAGE_LOCKOUT,
	input  wire logic       OVERTEMP,
	input  wire logic       OVERCURRENT,
	input  wire logic       SHORT_LOAD,
	input  wire logic       OPEN_LOAD,
	input  wire logic       BEMF_VALID,
	// measurement engine
	input  wire logic       ZMEAS_DONE,
	input  wire logic [7:0] ZMEAS_VALUE,
	input  wire logic       DIAG_WAVE_DONE,
	input  wire logic [7:0] CAL_LEVEL_IN,
	input  wire logic [7:0] CAL_PERIOD_IN,
	// drive control
	output logic [1:0]      DRIVE_MODE,
	output logic            ADAPT_LEVEL,
	output logic            ADAPT_FREQ,
	output logic            ZMEAS_RUN,
	output logic            DIAG_WAVE_RUN,
	output logic            CAL_RUN,
	output logic            FAULT_FLAG,
	// settings to the drive path
	output logic [7:0]      PEAK_DRIVE_LIMIT,
	output logic [7:0]      OPEN_LOOP_RESONANT_PERIOD,
	output logic [2:0]      FEEDBACK_BRAKE_GAIN,
	output logic [1:0]      LOOP_GAIN,
	output logic [3:0]      DISCHARGE_WAIT,
	output logic [1:0]      CROSSING_DETECT_WINDOW,
	output logic [7:0]      CAL_LEVEL,
	output logic [7:0]      CAL_PERIOD
);
	////////////////////////////////////////////////////////////////////////
	logic [1:0]  rst_sr;
	logic        rst_n;
	logic        scl_s, sda_s, en_s, trig_s;
	logic        scl_q, sda_q, trig_q;
	logic        scl_rise, scl_fall, i_start, i_stop;
	hd_sense_t   sense;
	hd_i2c_st_t  ist;
	logic [3:0]  bcnt;
	logic [7:0]  sh;
	logic [7:0]  ptr;
	logic        rw;
	hd_wr_t      wr;
	logic [7:0]  rdata;
	logic [7:0]  mode_reg, calcfg, timing, zres;
	logic        go, go_q, calibrated;
	logic        act, ol, ext_trig, rt_start;
	hd_cfg_t     cfg;
	logic        rt_busy, rt_zmeas, rt_dwave, rt_cal;
	logic        rt_done, rt_fault, zres_we, cal_we;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			rst_sr <= 2'h0;
		else
			rst_sr <= {rst_sr[0], 1'b1};
	end
	assign rst_n = rst_sr[1];

	hd_sync #(.W(10)) u_sync (
		.clk   (CLK),
		.rst_n (rst_n),
		.d     ({SCL, SDA_IN, EN, TRIG_PIN, UNDERVOLTAGE_LOCKOUT, OVERTEMP,
		         OVERCURRENT, SHORT_LOAD, OPEN_LOAD, BEMF_VALID}),
		.q     ({scl_s, sda_s, en_s, trig_s, sense})
	);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			trig_q <= 1'b0;
			go_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			trig_q <= trig_s;
			go_q <= go;
		end
	end

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign i_start = scl_s && scl_q && sda_q && !sda_s;
	assign i_stop = scl_s && scl_q && !sda_q && sda_s;

	////////////////////////////////////////////////////////////////////////
	// serial slave: open drain, only ever pulls low
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			SDA_OUT <= 1'b0;
		else
			SDA_OUT <= 1'b0;
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ist <= I_IDLE;
			bcnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			SDA_OEN <= 1'b1;
			wr <= '0;
		end else begin
			wr.stb <= 1'b0;
			if (i_stop) begin
				ist <= I_IDLE;
				SDA_OEN <= 1'b1;
			end else if (i_start) begin
				ist <= I_ADDR;
				bcnt <= 4'h0;
				SDA_OEN <= 1'b1;
			end else begin
				case (ist)
				I_ADDR, I_REG, I_WDATA: begin
					if (scl_rise) begin
						sh <= {sh[6:0], sda_s};
						bcnt <= bcnt + 4'h1;
					end else if (scl_fall && bcnt == 4'h8) begin
						bcnt <= 4'h0;
						if (ist == I_ADDR) begin
							if (sh[7:1] == HD_DEV_ADDR) begin
								rw <= sh[0];
								SDA_OEN <= 1'b0;
								ist <= I_AACK;
							end else begin
								ist <= I_IDLE;
							end
						end else if (ist == I_REG) begin
							ptr <= sh;
							SDA_OEN <= 1'b0;
							ist <= I_RACK;
						end else begin
							wr.stb <= 1'b1;
							wr.addr <= ptr;
							wr.data <= sh;
							ptr <= ptr + 8'h01;
							SDA_OEN <= 1'b0;
							ist <= I_DACK;
						end
					end
				end
				I_AACK, I_RACK, I_DACK: begin
					if (scl_fall) begin
						if (ist == I_AACK && rw) begin
							sh <= rdata;
							SDA_OEN <= rdata[7];
							ist <= I_RD;
						end else begin
							SDA_OEN <= 1'b1;
							ist <= (ist == I_AACK) ? I_REG : I_WDATA;
						end
					end
				end
				I_RD: begin
					if (scl_fall) begin
						if (bcnt == 4'h7) begin
							SDA_OEN <= 1'b1;
							ptr <= ptr + 8'h01;
							bcnt <= 4'h0;
							ist <= I_MACK;
						end else begin
							SDA_OEN <= sh[6];
							sh <= {sh[6:0], 1'b0};
							bcnt <= bcnt + 4'h1;
						end
					end
				end
				I_MACK: begin
					if (scl_rise)
						ist <= sda_s ? I_IDLE : I_RLOAD;
				end
				I_RLOAD: begin
					if (scl_fall) begin
						sh <= rdata;
						SDA_OEN <= rdata[7];
						ist <= I_RD;
					end
				end
				default: ist <= I_IDLE;
				endcase
			end
		end
	end

	always_comb begin
		case (ptr)
		HD_REG_STATUS: rdata = {5'h00, calibrated, rt_busy, FAULT_FLAG};
		HD_REG_MODE:   rdata = mode_reg;
		HD_REG_GO:     rdata = {7'h00, go};
		HD_REG_CALCFG: rdata = calcfg;
		HD_REG_PEAK:   rdata = PEAK_DRIVE_LIMIT;
		HD_REG_OLPER:  rdata = OPEN_LOOP_RESONANT_PERIOD;
		HD_REG_ZRES:   rdata = zres;
		HD_REG_CLEVEL: rdata = CAL_LEVEL;
		HD_REG_CPER:   rdata = CAL_PERIOD;
		HD_REG_TIMING: rdata = timing;
		default:       rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= HD_RST_BYTE;
			calcfg <= HD_RST_BYTE;
			timing <= HD_RST_BYTE;
			PEAK_DRIVE_LIMIT <= HD_RST_BYTE;
			OPEN_LOOP_RESONANT_PERIOD <= HD_RST_BYTE;
		end else if (wr.stb) begin
			case (wr.addr)
			HD_REG_MODE:   mode_reg <= wr.data;
			HD_REG_CALCFG: calcfg <= wr.data;
			HD_REG_TIMING: timing <= wr.data;
			HD_REG_PEAK:   PEAK_DRIVE_LIMIT <= wr.data;
			HD_REG_OLPER:  OPEN_LOOP_RESONANT_PERIOD <= wr.data;
			default:       mode_reg <= mode_reg;
			endcase
		end
	end

	assign act = mode_reg[HD_ACT_BIT];
	assign ol = mode_reg[HD_OL_BIT];
	assign cfg = {mode_reg[HD_MODE_LSB +: 2], calcfg[HD_CALT_LSB +: 2]};
	assign FEEDBACK_BRAKE_GAIN = calcfg[HD_BRK_LSB +: 3];
	assign LOOP_GAIN = calcfg[HD_GAIN_LSB +: 2];
	assign DISCHARGE_WAIT = timing[HD_DISC_LSB +: 4];
	assign CROSSING_DETECT_WINDOW = timing[HD_ZC_LSB +: 2];

	// results: cleared only by reset, never by the enable pin
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			zres <= HD_RST_BYTE;
			CAL_LEVEL <= HD_RST_BYTE;
			CAL_PERIOD <= HD_RST_BYTE;
			calibrated <= 1'b0;
		end else begin
			if (zres_we)
				zres <= ZMEAS_VALUE;
			else if (wr.stb && wr.addr == HD_REG_ZRES)
				zres <= wr.data;
			if (cal_we) begin
				CAL_LEVEL <= CAL_LEVEL_IN;
				calibrated <= 1'b1;
			end else if (wr.stb && wr.addr == HD_REG_CLEVEL) begin
				CAL_LEVEL <= wr.data;
			end
			if (cal_we && !act)
				CAL_PERIOD <= CAL_PERIOD_IN;
			else if (wr.stb && wr.addr == HD_REG_CPER)
				CAL_PERIOD <= wr.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger bit: host write wins over the self-clear
	assign ext_trig = trig_s && !trig_q &&
		mode_reg[HD_TRIGF_LSB +: 2] != HD_TRIG_NONE;
	assign rt_start = go && !go_q && en_s;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			go <= 1'b0;
		else if (wr.stb && wr.addr == HD_REG_GO)
			go <= wr.data[0];
		else if (ext_trig && !go)
			go <= 1'b1;
		else if (ext_trig && rt_cal && cfg.cal_time == HD_CALT_TRIG)
			go <= 1'b0;
		else if (rt_done)
			go <= 1'b0;
	end

	// fault flag: a new fault wins over the clear at start
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			FAULT_FLAG <= 1'b0;
		else if (rt_fault)
			FAULT_FLAG <= 1'b1;
		else if (rt_start)
			FAULT_FLAG <= 1'b0;
	end

	hd_routine #(
		.CYC0 (CAL_CYC_250),
		.CYC1 (CAL_CYC_500),
		.CYC2 (CAL_CYC_1S)
	) u_routine (
		.clk        (CLK),
		.rst_n      (rst_n),
		.start      (rt_start),
		.go         (go),
		.cfg        (cfg),
		.sense      (sense),
		.zmeas_done (ZMEAS_DONE),
		.wave_done  (DIAG_WAVE_DONE),
		.busy       (rt_busy),
		.zmeas      (rt_zmeas),
		.dwave      (rt_dwave),
		.calrun     (rt_cal),
		.done       (rt_done),
		.fault_set  (rt_fault),
		.zres_we    (zres_we),
		.cal_we     (cal_we)
	);

	////////////////////////////////////////////////////////////////////////
	// drive selection
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			DRIVE_MODE <= HD_DRV_CL_ECC;
			ADAPT_LEVEL <= 1'b0;
			ADAPT_FREQ <= 1'b0;
			ZMEAS_RUN <= 1'b0;
			DIAG_WAVE_RUN <= 1'b0;
			CAL_RUN <= 1'b0;
		end else begin
			if (ol)
				DRIVE_MODE <= act ? HD_DRV_OL_ECC : HD_DRV_OL_RES;
			else
				DRIVE_MODE <= act ? HD_DRV_CL_ECC : HD_DRV_CL_RES;
			ADAPT_LEVEL <= !ol && calibrated;
			ADAPT_FREQ <= !ol && calibrated && !act;
			ZMEAS_RUN <= rt_zmeas;
			DIAG_WAVE_RUN <= rt_dwave;
			CAL_RUN <= rt_cal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	property p_ack_addr;
		ist == I_ADDR && scl_fall && bcnt == 4'h8 && !i_start && !i_stop
			&& sh[7:1] == HD_DEV_ADDR |=> (!SDA_OEN && ist == I_AACK)[*2];
	endproperty
	a_ack_addr: assert property (p_ack_addr)
		else $error("own address not acknowledged");

	property p_ack_data;
		wr.stb |-> !SDA_OEN && ist == I_DACK;
	endproperty
	a_ack_data: assert property (p_ack_data)
		else $error("data byte not acknowledged");

	property p_wptr;
		wr.stb |-> ptr == wr.addr + 8'h01;
	endproperty
	a_wptr: assert property (p_wptr)
		else $error("write pointer did not advance");

	property p_rptr;
		ist == I_RD && scl_fall && bcnt == 4'h7 && !i_start && !i_stop
			|=> ptr == $past(ptr) + 8'h01 && ist == I_MACK;
	endproperty
	a_rptr: assert property (p_rptr)
		else $error("read pointer did not advance");

	property p_nack;
		ist == I_MACK && scl_rise && sda_s && !i_start && !i_stop
			|=> ist == I_IDLE && SDA_OEN;
	endproperty
	a_nack: assert property (p_nack)
		else $error("read continued after not-acknowledge");

	property p_ol_ecc;
		ol && act |=> DRIVE_MODE == HD_DRV_OL_ECC;
	endproperty
	a_ol_ecc: assert property (p_ol_ecc)
		else $error("eccentric open-loop not selected");

	property p_ol_res;
		ol && !act |=> DRIVE_MODE == HD_DRV_OL_RES;
	endproperty
	a_ol_res: assert property (p_ol_res)
		else $error("resonant open-loop not selected");

	property p_adapt;
		calibrated && !ol |=> ADAPT_LEVEL && ADAPT_FREQ == !$past(act);
	endproperty
	a_adapt: assert property (p_adapt)
		else $error("closed-loop adaptation wrong");

	property p_go_clr;
		rt_done && !wr.stb && !ext_trig |=> !go;
	endproperty
	a_go_clr: assert property (p_go_clr)
		else $error("trigger bit not cleared on completion");

	property p_abort_fault;
		rt_busy && go && (sense.undervoltage_lockout || sense.hot)
			|-> ##[1:3] FAULT_FLAG;
	endproperty
	a_abort_fault: assert property (p_abort_fault)
		else $error("abort did not raise fault flag");

	property p_cper_keep;
		cal_we && act && !wr.stb |=> $stable(CAL_PERIOD);
	endproperty
	a_cper_keep: assert property (p_cper_keep)
		else $error("resonant result written for eccentric actuator");

	c_read: cover property (ist == I_RLOAD && scl_fall);
	c_multi_write: cover property (wr.stb ##[1:200] wr.stb);
endmodule

// *** verilog/hd_pkg.sv ***
package hd_pkg;
	localparam logic [6:0] HD_DEV_ADDR   = 7'h5a;
	// register offsets
	localparam logic [7:0] HD_REG_STATUS = 8'h00;
	localparam logic [7:0] HD_REG_MODE   = 8'h01;
	localparam logic [7:0] HD_REG_GO     = 8'h02;
	localparam logic [7:0] HD_REG_CALCFG = 8'h03;
	localparam logic [7:0] HD_REG_PEAK   = 8'h04;
	localparam logic [7:0] HD_REG_OLPER  = 8'h05;
	localparam logic [7:0] HD_REG_ZRES   = 8'h06;
	localparam logic [7:0] HD_REG_CLEVEL = 8'h07;
	localparam logic [7:0] HD_REG_CPER   = 8'h08;
	localparam logic [7:0] HD_REG_TIMING = 8'h09;
	localparam logic [7:0] HD_RST_BYTE   = 8'h00;
	// field positions
	localparam int HD_MODE_LSB  = 0;
	localparam int HD_ACT_BIT   = 2;
	localparam int HD_OL_BIT    = 3;
	localparam int HD_TRIGF_LSB = 4;
	localparam int HD_CALT_LSB  = 0;
	localparam int HD_BRK_LSB   = 2;
	localparam int HD_GAIN_LSB  = 5;
	localparam int HD_DISC_LSB  = 0;
	localparam int HD_ZC_LSB    = 4;
	// codes
	localparam logic [1:0] HD_MODE_DIAG  = 2'h2;
	localparam logic [1:0] HD_MODE_CAL   = 2'h3;
	localparam logic [1:0] HD_TRIG_NONE  = 2'h0;
	localparam logic [1:0] HD_CALT_TRIG  = 2'h3;
	localparam logic [1:0] HD_DRV_CL_ECC = 2'h0;
	localparam logic [1:0] HD_DRV_CL_RES = 2'h1;
	localparam logic [1:0] HD_DRV_OL_ECC = 2'h2;
	localparam logic [1:0] HD_DRV_OL_RES = 2'h3;
	// timing
	localparam int unsigned HD_CLK_HZ     = 20000000;
	localparam int unsigned HD_CAL_T0_MS  = 250;
	localparam int unsigned HD_CAL_T1_MS  = 500;
	localparam int unsigned HD_CAL_T2_MS  = 1000;
	localparam int unsigned HD_CYC_PER_MS = HD_CLK_HZ / 1000;
	localparam int unsigned HD_CAL_CYC0   = HD_CAL_T0_MS * HD_CYC_PER_MS;
	localparam int unsigned HD_CAL_CYC1   = HD_CAL_T1_MS * HD_CYC_PER_MS;
	localparam int unsigned HD_CAL_CYC2   = HD_CAL_T2_MS * HD_CYC_PER_MS;
	localparam int HD_CNT_W = 25;

	typedef struct packed {
		logic       stb;
		logic [7:0] addr;
		logic [7:0] data;
	} hd_wr_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] cal_time;
	} hd_cfg_t;

	typedef struct packed {
		logic undervoltage_lockout;
		logic hot;
		logic ocp;
		logic shrt;
		logic open;
		logic bemf;
	} hd_sense_t;

	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WDATA, I_DACK,
		I_RD, I_MACK, I_RLOAD
	} hd_i2c_st_t;

	typedef enum logic [1:0] {RT_IDLE, RT_ZMEAS, RT_DWAVE, RT_CAL} hd_rt_st_t;
endpackage

// *** verilog/hd_routine.sv ***
`timescale 1ns/1ps
module hd_routine
	import hd_pkg::*;
#(
	parameter int unsigned CYC0 = HD_CAL_CYC0,
	parameter int unsigned CYC1 = HD_CAL_CYC1,
	parameter int unsigned CYC2 = HD_CAL_CYC2
)(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic       go,
	input  hd_cfg_t         cfg,
	input  hd_sense_t       sense,
	input  wire logic       zmeas_done,
	input  wire logic       wave_done,
	output logic            busy,
	output logic            zmeas,
	output logic            dwave,
	output logic            calrun,
	output logic            done,
	output logic            fault_set,
	output logic            zres_we,
	output logic            cal_we
);
	hd_rt_st_t st;
	logic [HD_CNT_W-1:0] cnt;
	logic [HD_CNT_W-1:0] limit;
	logic crit;

	assign crit = sense.undervoltage_lockout | sense.hot | sense.ocp;
	assign busy = st != RT_IDLE;
	assign zmeas = st == RT_ZMEAS;
	assign dwave = st == RT_DWAVE;
	assign calrun = st == RT_CAL;

	always_comb begin
		case (cfg.cal_time)
		2'h0: limit = HD_CNT_W'(CYC0);
		2'h1: limit = HD_CNT_W'(CYC1);
		2'h2: limit = HD_CNT_W'(CYC2);
		default: limit = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= RT_IDLE;
			cnt <= '0;
			done <= 1'b0;
			fault_set <= 1'b0;
			zres_we <= 1'b0;
			cal_we <= 1'b0;
		end else begin
			done <= 1'b0;
			fault_set <= 1'b0;
			zres_we <= 1'b0;
			cal_we <= 1'b0;
			case (st)
			RT_IDLE: begin
				cnt <= '0;
				if (start && cfg.mode == HD_MODE_DIAG)
					st <= RT_ZMEAS;
				else if (start && cfg.mode == HD_MODE_CAL)
					st <= RT_CAL;
			end
			RT_ZMEAS: begin
				// overcurrent cannot trip the small measuring current
				if (sense.undervoltage_lockout || sense.hot) begin
					fault_set <= 1'b1;
					done <= 1'b1;
					st <= RT_IDLE;
				end else if (!go) begin
					st <= RT_IDLE;
				end else if (zmeas_done) begin
					zres_we <= 1'b1;
					st <= RT_DWAVE;
				end
			end
			RT_DWAVE: begin
				if (crit || sense.shrt || sense.open) begin
					fault_set <= 1'b1;
					done <= 1'b1;
					st <= RT_IDLE;
				end else if (!go) begin
					st <= RT_IDLE;
				end else if (wave_done) begin
					fault_set <= !sense.bemf;
					done <= 1'b1;
					st <= RT_IDLE;
				end
			end
			RT_CAL: begin
				if (crit) begin
					fault_set <= 1'b1;
					done <= 1'b1;
					st <= RT_IDLE;
				end else if (cfg.cal_time == HD_CALT_TRIG) begin
					if (!go) begin
						cal_we <= 1'b1;
						done <= 1'b1;
						st <= RT_IDLE;
					end
				end else if (!go) begin
					st <= RT_IDLE;
				end else if (cnt >= limit - HD_CNT_W'(1)) begin
					cal_we <= 1'b1;
					done <= 1'b1;
					st <= RT_IDLE;
				end else begin
					cnt <= cnt + HD_CNT_W'(1);
				end
			end
			default: st <= RT_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_zmeas_abort;
		st == RT_ZMEAS && sense.hot |=> st == RT_IDLE && fault_set;
	endproperty
	a_zmeas_abort: assert property (p_zmeas_abort)
		else $error("impedance step not aborted on overtemperature");

	property p_cal_start;
		st == RT_IDLE && start && cfg.mode == HD_MODE_CAL
			|=> st == RT_CAL ##1 (st == RT_CAL || done || !go);
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration mode did not start calibration");

	property p_diag_order;
		st == RT_IDLE && start && cfg.mode == HD_MODE_DIAG |=> zmeas;
	endproperty
	a_diag_order: assert property (p_diag_order)
		else $error("diagnostic did not begin with impedance step");

	c_cal_done: cover property (cal_we);
	c_diag_fault: cover property (dwave && fault_set);
endmodule

// *** verilog/hd_sync.sv ***
`timescale 1ns/1ps
module hd_sync
	import hd_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
